// ### rtl/tta_core.sv
`timescale 1ns/1ps
module tta_core #(
	parameter int TEMP_W = 16
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic [1:0] addr_strap_low_i,
	input wire logic addr_strap_high_i,
	input wire logic conv_valid_i,
	input wire logic [TEMP_W-1:0] conv_data_i,
	output logic alert_o
);
	// The register map and the serial engine only serve 16-bit results.
	if (TEMP_W != 16) begin : g_bad_width
		$error("TEMP_W must be 16");
	end

	logic scl_s;
	logic sda_s;
	logic scl_d1_q;
	logic sda_d1_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	tta_pkg::tta_state_t state_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic first_q;
	logic rw_q;
	logic ack_q;
	logic [1:0] wr_idx_q;
	logic [7:0] wr_msb_q;
	logic tx_lsb_q;
	logic [7:0] ptr_q;
	logic [6:0] addr_q;
	logic strap_done_q;
	logic wr_commit;
	logic read_hit;
	logic [15:0] temp_q;
	logic [15:0] low_thr_q;
	logic [15:0] high_thr_q;
	logic [15:0] cfg_q;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	logic alert_act_q;
	logic wait_high_q;
	logic [1:0] fault_cnt_q;
	logic qual;
	logic fire;
	logic sleep_set;
	logic latch_mode;
	logic conv_tick_q;

	tta_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.async_i(scl_i),
		.level_o(scl_s)
	);

	tta_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.async_i(sda_i),
		.level_o(sda_s)
	);

	// Delayed copies of the filtered lines give the edge and condition detectors.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= scl_s;
			sda_d1_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d1_q;
	assign scl_fall = ~scl_s & scl_d1_q;
	assign start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
	assign stop_det = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

	// Straps are caught once, one cycle after reset release, never under reset.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_q <= 7'h00;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			addr_q <= {tta_pkg::ADDR_TOP, addr_strap_high_i ? tta_pkg::ADDR_MID_SCL
				: tta_pkg::ADDR_MID_OTHER, addr_strap_low_i};
		end
	end

	// Register read view; unmapped pointers read zero.
	always_comb begin
		rd_word = 16'h0000;
		unique case (ptr_q)
			tta_pkg::PTR_TEMP: rd_word = temp_q;
			tta_pkg::PTR_CFG: rd_word = cfg_q | ({15'h0000, alert_o} << tta_pkg::CFG_ALERT_BIT);
			tta_pkg::PTR_LOW: rd_word = low_thr_q;
			tta_pkg::PTR_HIGH: rd_word = high_thr_q;
			default: rd_word = 16'h0000;
		endcase
	end

	assign wr_word = {wr_msb_q, shift_q[6:0], sda_s};

	// Serial target engine: receive, acknowledge and transmit on filtered SCL edges.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= tta_pkg::ST_IDLE;
			bit_cnt_q <= 3'd0;
			shift_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			wr_idx_q <= 2'd0;
			wr_msb_q <= 8'h00;
			tx_lsb_q <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else if (start_det) begin
			state_q <= tta_pkg::ST_RX;
			bit_cnt_q <= 3'd0;
			first_q <= 1'b1;
			wr_idx_q <= 2'd0;
			sda_oe_n_o <= 1'b1;
		end else if (stop_det) begin
			state_q <= tta_pkg::ST_IDLE;
			sda_oe_n_o <= 1'b1;
		end else begin
			unique case (state_q)
				tta_pkg::ST_IDLE: begin
					sda_oe_n_o <= 1'b1;
				end
				tta_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 3'd1;
						if (bit_cnt_q == 3'd7) begin
							state_q <= tta_pkg::ST_ACK;
							if (first_q) begin
								ack_q <= (shift_q[6:0] == addr_q);
								rw_q <= sda_s;
							end else begin
								ack_q <= 1'b1;
								if (wr_idx_q == 2'd1) begin
									wr_msb_q <= {shift_q[6:0], sda_s};
								end
							end
						end
					end
				end
				tta_pkg::ST_ACK: begin
					if (scl_fall) begin
						sda_oe_n_o <= ~ack_q;
						state_q <= tta_pkg::ST_ACKH;
					end
				end
				tta_pkg::ST_ACKH: begin
					if (scl_fall) begin
						bit_cnt_q <= 3'd0;
						first_q <= 1'b0;
						if (!ack_q) begin
							sda_oe_n_o <= 1'b1;
							state_q <= tta_pkg::ST_IDLE;
						end else if (first_q && rw_q) begin
							sda_oe_n_o <= rd_word[15];
							shift_q <= {rd_word[14:8], 1'b0};
							tx_lsb_q <= 1'b1;
							state_q <= tta_pkg::ST_TX;
						end else begin
							sda_oe_n_o <= 1'b1;
							if (!first_q) begin
								wr_idx_q <= (wr_idx_q == 2'd2) ? 2'd1 : wr_idx_q + 2'd1;
							end
							state_q <= tta_pkg::ST_RX;
						end
					end
				end
				tta_pkg::ST_TX: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 3'd1;
						if (bit_cnt_q == 3'd7) begin
							state_q <= tta_pkg::ST_MACK;
						end
					end else if (scl_fall) begin
						sda_oe_n_o <= shift_q[7];
						shift_q <= {shift_q[6:0], 1'b0};
					end
				end
				tta_pkg::ST_MACK: begin
					if (scl_fall) begin
						sda_oe_n_o <= 1'b1;
					end else if (scl_rise) begin
						if (sda_s) begin
							state_q <= tta_pkg::ST_IDLE;
						end else begin
							shift_q <= tx_lsb_q ? rd_word[7:0] : rd_word[15:8];
							tx_lsb_q <= ~tx_lsb_q;
							state_q <= tta_pkg::ST_TX;
						end
					end
				end
				default: begin
					state_q <= tta_pkg::ST_IDLE;
					sda_oe_n_o <= 1'b1;
				end
			endcase
		end
	end

	// The pin only ever pulls low; the enable carries the data.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	assign wr_commit = (state_q == tta_pkg::ST_RX) && scl_rise && (bit_cnt_q == 3'd7)
		&& !first_q && (wr_idx_q == 2'd2);
	assign read_hit = (state_q == tta_pkg::ST_ACKH) && scl_fall && ack_q && first_q && rw_q;

	// Pointer byte is the first data byte of a write and persists across reads.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptr_q <= tta_pkg::PTR_TEMP;
		end else if ((state_q == tta_pkg::ST_RX) && scl_rise && (bit_cnt_q == 3'd7)
			&& !first_q && (wr_idx_q == 2'd0)) begin
			ptr_q <= {shift_q[6:0], sda_s};
		end
	end

	// Register writes land when the second byte of a word completes.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_thr_q <= tta_pkg::LOW_RST;
			high_thr_q <= tta_pkg::HIGH_RST;
			cfg_q <= tta_pkg::CFG_RST;
		end else if (wr_commit) begin
			unique case (ptr_q)
				tta_pkg::PTR_CFG: cfg_q <= (wr_word & tta_pkg::CFG_WMASK)
					| (tta_pkg::CFG_RST & ~tta_pkg::CFG_WMASK);
				tta_pkg::PTR_LOW: low_thr_q <= wr_word & tta_pkg::THR_MASK;
				tta_pkg::PTR_HIGH: high_thr_q <= wr_word & tta_pkg::THR_MASK;
				default: ;
			endcase
		end
	end

	// Conversion results are taken while awake; zero until the first one.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			temp_q <= tta_pkg::TEMP_RST;
		end else if (conv_valid_i && !cfg_q[tta_pkg::CFG_SLEEP_BIT]) begin
			temp_q <= conv_data_i;
		end
	end

	assign latch_mode = cfg_q[tta_pkg::CFG_LATCH_BIT];
	assign sleep_set = wr_commit && (ptr_q == tta_pkg::PTR_CFG) && wr_word[tta_pkg::CFG_SLEEP_BIT];

	// Pending condition: in comparator mode it follows the alert state, in latched
	// mode it alternates between high and strictly-below-low.
	always_comb begin
		if (latch_mode) begin
			qual = wait_high_q ? ($signed(temp_q) >= $signed(high_thr_q))
				: ($signed(temp_q) < $signed(low_thr_q));
		end else begin
			qual = alert_act_q ? ($signed(temp_q) <= $signed(low_thr_q))
				: ($signed(temp_q) >= $signed(high_thr_q));
		end
	end

	// Fire when this reading completes the selected run of one to four.
	assign fire = conv_tick_q && qual
		&& (fault_cnt_q == cfg_q[tta_pkg::CFG_FAULT_LSB +: 2]);

	// Evaluation runs one cycle after a result lands, on the stored value.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_tick_q <= 1'b0;
		end else begin
			conv_tick_q <= conv_valid_i && !cfg_q[tta_pkg::CFG_SLEEP_BIT];
		end
	end

	// Run counter; a failing reading restarts it, which keeps noise from alerting.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_cnt_q <= 2'd0;
		end else if (conv_tick_q) begin
			if (!qual || fire) begin
				fault_cnt_q <= 2'd0;
			end else begin
				fault_cnt_q <= fault_cnt_q + 2'd1;
			end
		end
	end

	// Alert state; in latched mode a set in the same cycle as a clear wins.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alert_act_q <= 1'b0;
			wait_high_q <= 1'b1;
		end else if (!latch_mode) begin
			wait_high_q <= 1'b1;
			if (fire) begin
				alert_act_q <= ~alert_act_q;
			end
		end else if (fire) begin
			alert_act_q <= 1'b1;
			wait_high_q <= ~wait_high_q;
		end else if (read_hit || sleep_set) begin
			alert_act_q <= 1'b0;
		end
	end

	// Pin level applies the selected polarity to the alert state.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alert_o <= 1'b1;
		end else begin
			alert_o <= alert_act_q ~^ cfg_q[tta_pkg::CFG_LEVEL_BIT];
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_addr_done;
		(state_q == tta_pkg::ST_ACK) && ack_q && first_q && scl_fall;
	endsequence

	a_ack_drive: assert property (s_addr_done |=> !sda_oe_n_o)
		else $error("address match not acknowledged");
	a_sample_rise: assert property ((state_q == tta_pkg::ST_RX) && scl_rise
		|=> shift_q[0] == $past(sda_s))
		else $error("bit not sampled on SCL rise");
	a_thr_low: assert property (low_thr_q[3:0] == 4'h0 && high_thr_q[3:0] == 4'h0)
		else $error("threshold low nibble not zero");
	a_cmp_rise: assert property (!latch_mode && !alert_act_q && fire
		|=> alert_act_q)
		else $error("comparator alert did not rise");
	a_cmp_fall: assert property (!latch_mode && alert_act_q && conv_tick_q && qual
		&& fault_cnt_q == cfg_q[tta_pkg::CFG_FAULT_LSB +: 2] |=> !alert_act_q)
		else $error("comparator alert did not fall");
	a_read_clear: assert property (latch_mode && read_hit && !fire
		|=> !alert_act_q)
		else $error("register read did not clear alert");
	a_sleep_clear: assert property (latch_mode && sleep_set && !fire
		|=> !alert_act_q)
		else $error("sleep write did not clear alert");
	a_run_restart: assert property (conv_tick_q && !qual |=> fault_cnt_q == 2'd0)
		else $error("fault run not restarted");
	a_pin_level: assert property (alert_o == ($past(alert_act_q) ~^
		$past(cfg_q[tta_pkg::CFG_LEVEL_BIT])) || $past(!rstn_i))
		else $error("alert pin polarity wrong");
	a_temp_load: assert property (conv_valid_i && !cfg_q[tta_pkg::CFG_SLEEP_BIT]
		|=> temp_q == $past(conv_data_i))
		else $error("temperature result not loaded");
endmodule

// ### rtl/tta_pkg.sv
package tta_pkg;
	// Register pointer values.
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CFG = 8'h01;
	localparam logic [7:0] PTR_LOW = 8'h02;
	localparam logic [7:0] PTR_HIGH = 8'h03;
	// Values after power-up.
	localparam logic [15:0] TEMP_RST = 16'h0000;
	localparam logic [15:0] LOW_RST = 16'h2580;
	localparam logic [15:0] HIGH_RST = 16'h2800;
	localparam logic [15:0] CFG_RST = 16'h4080;
	// Threshold bits that keep their written value; the low four stay zero.
	localparam logic [15:0] THR_MASK = 16'hfff0;
	// Configuration bits software may change; bit 14 stays one.
	localparam logic [15:0] CFG_WMASK = 16'h9fc0;
	// Configuration field positions.
	localparam int CFG_ALERT_BIT = 5;
	localparam int CFG_SLEEP_BIT = 8;
	localparam int CFG_LATCH_BIT = 9;
	localparam int CFG_LEVEL_BIT = 10;
	localparam int CFG_FAULT_LSB = 11;
	// Target address pieces set by the straps.
	localparam logic [2:0] ADDR_TOP = 3'b100;
	localparam logic [1:0] ADDR_MID_SCL = 2'b01;
	localparam logic [1:0] ADDR_MID_OTHER = 2'b10;
	// Serial engine states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_ACKH = 3'b011,
		ST_TX = 3'b100,
		ST_MACK = 3'b101
	} tta_state_t;
endpackage

// ### rtl/tta_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only when stages two and three agree.
module tta_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic async_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// The first stage feeds only the second, so metastability stays contained.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Agreement of two settled stages filters single-sample glitches.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_o <= RST_VAL;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end
endmodule

// ### tb/temp_threshold_alert_i2c_target_tb_top.sv
`timescale 1ns/1ps
// Bench top: clock, reset, straps, conversion pulses and the bus controller model.
module temp_threshold_alert_i2c_target_tb_top;
	logic core_clk_i;
	logic rstn_i;
	logic scl_w;
	logic ctrl_sda;
	logic sda_w;
	logic sda_o;
	logic sda_oe_n_o;
	logic [1:0] strap_low;
	logic strap_high;
	logic conv_valid;
	logic [15:0] conv_data;
	logic alert_o;
	logic [6:0] dev_addr;
	int errors;
	int checked;
	// Open-drain wire with a pull-up: low whenever either party pulls it.
	assign sda_w = ctrl_sda & (sda_oe_n_o ? 1'b1 : sda_o);
	tta_core #(.TEMP_W(16)) dut_u (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.scl_i(scl_w),
		.sda_i(sda_w),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o),
		.addr_strap_low_i(strap_low),
		.addr_strap_high_i(strap_high),
		.conv_valid_i(conv_valid),
		.conv_data_i(conv_data),
		.alert_o(alert_o)
	);
	tta_i2c_ctrl ctrl_u (
		.clk_i(core_clk_i),
		.sda_i(sda_w),
		.scl_o(scl_w),
		.sda_o(ctrl_sda)
	);
	// Core clock at 250 MHz.
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	// Straps are only captured after release, so every strap change goes through a reset.
	task automatic do_reset(input logic h, input logic [1:0] l);
		@(negedge core_clk_i);
		rstn_i = 1'b0;
		strap_high = h;
		strap_low = l;
		dev_addr = {3'b100, h ? 2'b01 : 2'b10, l};
		repeat (16) @(negedge core_clk_i);
		rstn_i = 1'b1;
		repeat (10) @(negedge core_clk_i);
	endtask
	task automatic put_ptr(input logic [7:0] p);
		logic a;
		ctrl_u.start();
		ctrl_u.wbyte({dev_addr, 1'b0}, a);
		chk1(a, 1'b1);
		ctrl_u.wbyte(p, a);
		chk1(a, 1'b1);
	endtask
	task automatic wr_reg(input logic [7:0] p, input logic [15:0] v);
		logic a;
		put_ptr(p);
		ctrl_u.wbyte(v[15:8], a);
		ctrl_u.wbyte(v[7:0], a);
		ctrl_u.stop();
	endtask
	// Reads the register the pointer already selects.
	task automatic rd_cur(output logic [15:0] v);
		logic a;
		ctrl_u.start();
		ctrl_u.wbyte({dev_addr, 1'b1}, a);
		chk1(a, 1'b1);
		ctrl_u.rbyte(1'b0, v[15:8]);
		ctrl_u.rbyte(1'b1, v[7:0]);
		ctrl_u.stop();
	endtask
	task automatic rd_reg(input logic [7:0] p, input logic [15:0] exp);
		logic [15:0] v;
		put_ptr(p);
		rd_cur(v);
		chk16(v, exp);
	endtask
	// One conversion pulse, then the alert pin is judged once the result has settled.
	task automatic conv(input logic [15:0] t, input logic exp_alert);
		@(negedge core_clk_i);
		conv_valid = 1'b1;
		conv_data = t;
		@(negedge core_clk_i);
		conv_valid = 1'b0;
		repeat (8) @(negedge core_clk_i);
		chk1(alert_o, exp_alert);
	endtask
	task automatic test_regs();
		logic [15:0] v;
		rd_reg(8'h00, 16'h0000);
		rd_reg(8'h02, 16'h2580);
		rd_reg(8'h03, 16'h2800);
		rd_cur(v);
		chk16(v, 16'h2800);
		wr_reg(8'h02, 16'ha5cf);
		rd_reg(8'h02, 16'ha5c0);
		rd_reg(8'h05, 16'h0000);
		rd_reg(8'h01, 16'h40a0);
		chk1(sda_o, 1'b0);
		$display("test regs done");
	endtask
	task automatic test_temp();
		conv(16'hf380, 1'b1);
		rd_reg(8'h00, 16'hf380);
		wr_reg(8'h00, 16'h1234);
		rd_reg(8'h00, 16'hf380);
		$display("test temp done");
	endtask
	// Comparator mode, every fault count, then a broken run that must restart the count.
	task automatic test_cmp();
		wr_reg(8'h02, 16'h0800);
		wr_reg(8'h03, 16'h1000);
		for (int n = 1; n <= 4; n++) begin
			wr_reg(8'h01, {3'b000, 2'(n - 1), 11'h000});
			for (int k = 1; k <= n; k++) conv(16'h1000, k < n);
			for (int k = 1; k <= n; k++) conv(16'h0800, k == n);
		end
		wr_reg(8'h01, 16'h0800);
		conv(16'h1000, 1'b1);
		conv(16'h0ff0, 1'b1);
		conv(16'h1000, 1'b1);
		conv(16'h1000, 1'b0);
		rd_reg(8'h00, 16'h1000);
		chk1(alert_o, 1'b0);
		conv(16'h0800, 1'b0);
		conv(16'h0800, 1'b1);
		$display("test cmp done");
	endtask
	// Latched mode with an active-high pin: read clears, alternation, sleep clear, back to comparator.
	task automatic test_latch();
		wr_reg(8'h01, 16'h0600);
		conv(16'h1000, 1'b1);
		rd_reg(8'h03, 16'h1000);
		chk1(alert_o, 1'b0);
		conv(16'h1000, 1'b0);
		conv(16'h0800, 1'b0);
		conv(16'h07f0, 1'b1);
		rd_reg(8'h02, 16'h0800);
		chk1(alert_o, 1'b0);
		conv(16'h1000, 1'b1);
		wr_reg(8'h01, 16'h0700);
		chk1(alert_o, 1'b0);
		wr_reg(8'h01, 16'h0400);
		conv(16'h1000, 1'b1);
		rd_reg(8'h00, 16'h1000);
		chk1(alert_o, 1'b1);
		$display("test latch done");
	endtask
	// Every strap setting: the own address is acknowledged, the other pattern is not.
	task automatic test_addr();
		logic a;
		for (int k = 0; k < 8; k++) begin
			do_reset(k[2], k[1:0]);
			ctrl_u.start();
			ctrl_u.wbyte({dev_addr, 1'b0}, a);
			ctrl_u.stop();
			chk1(a, 1'b1);
			ctrl_u.start();
			ctrl_u.wbyte({dev_addr ^ 7'h0c, 1'b0}, a);
			ctrl_u.stop();
			chk1(a, 1'b0);
		end
		$display("test addr done");
	endtask
	task automatic give_verdict();
		$display("Counts: %0d checks, %0d mismatches", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence; all inputs get a value at time zero.
	initial begin
		errors = 0;
		checked = 0;
		rstn_i = 1'b0;
		strap_high = 1'b0;
		strap_low = 2'b01;
		conv_valid = 1'b0;
		conv_data = 16'h0000;
		dev_addr = 7'h49;
		do_reset(1'b0, 2'b01);
		test_regs();
		test_temp();
		test_cmp();
		test_latch();
		test_addr();
		give_verdict();
	end
	// Watchdog: the tests need roughly a third of this span, so a hang cannot pass unseen.
	initial begin
		#300000;
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule

// ### tb/tta_i2c_ctrl.sv
`timescale 1ns/1ps
// Bus controller model: makes SCL and pulls SDA open-drain, pacing on the core clock's falling edge.
module tta_i2c_ctrl (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// Both lines start released, so the pull-ups hold them high and SCL stands still.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// A quarter of the 80 ns link period; the device's sync delay fits inside one low phase.
	task automatic qtr();
		repeat (5) @(negedge clk_i);
	endtask
	// Start or repeated start: SDA falls while SCL is high.
	task automatic start();
		sda_o = 1'b1;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_o = 1'b0;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask
	// One bit: SDA only changes while SCL is low, the wire is sampled while SCL is high.
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		qtr();
		scl_o = 1'b1;
		qtr();
		r = sda_i;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask
	// Stop: SDA rises while SCL is high, after which both lines rest high.
	task automatic stop();
		sda_o = 1'b0;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_o = 1'b1;
		qtr();
		qtr();
	endtask
	// Sends a byte and reports whether the device pulled the ninth bit low.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Reads a byte; last set means a not-acknowledge closes the read.
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule
